// >>> common/ssram_pkg.sv
// Constants, encodings and timing for the serial SRAM host controller
package ssram_pkg;
    // Opcodes understood by the memory
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_RD_MODE = 8'h05;
    localparam logic [7:0] OP_WR_MODE = 8'h01;
    localparam logic [7:0] OP_DUAL = 8'h3B;
    localparam logic [7:0] OP_QUAD = 8'h38;
    localparam logic [7:0] OP_RST_W = 8'hFF;

    // Operating-mode register field and codes
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_PAGE = 2'h2;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [5:0] MODE_RSVD_BITS = 6'h00;

    localparam int ADDR_BITS = 24;
    localparam logic [5:0] DUAL_DUMMY_CLKS = 6'h04;

    // Host register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_WIDTH_LO = 1;
    localparam int ST_ERR_POS = 4;
    localparam int ST_MODE_LO = 8;

    // Serial clock half period in system clocks
    localparam int SCK_HALF_DIV = 4;

    // Chip-select spacing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CS_SETUP_NS = 32;
    localparam int CS_HOLD_NS = 50;
    localparam int CS_DISABLE_NS = 32;
    localparam logic [3:0] CS_SETUP_CYC = 4'((CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] CS_HOLD_CYC = 4'((CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] CS_DISABLE_CYC =
        4'((CS_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        W_SINGLE = 2'h0,
        W_DUAL = 2'h1,
        W_QUAD = 2'h2
    } ssram_width_type;

    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_WRITE = 3'h1,
        CMD_RD_MODE = 3'h2,
        CMD_WR_MODE = 3'h3,
        CMD_DUAL = 3'h4,
        CMD_QUAD = 3'h5,
        CMD_RST_W = 3'h6,
        CMD_RECOVER = 3'h7
    } ssram_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_TX = 3'b011,
        ST_DUMMY = 3'b010,
        ST_RX = 3'b110,
        ST_HOLD = 3'b111,
        ST_GAP = 3'b101
    } ssram_state_type;
endpackage

// >>> logic/ssram_tick.sv
// Enable-pulse divider that paces the serial clock edges
`timescale 1ns/1ps
module ssram_tick #(
    parameter int unsigned DIV = 4
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic run_in,
    output logic tick_out
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_r;

    // Restart on every run so the first edge is a full half period after the start
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_r <= '0;
            tick_out <= 1'b0;
        end
        else if (!run_in)
        begin
            cnt_r <= '0;
            tick_out <= 1'b0;
        end
        else if (cnt_r == CW'(DIV - 1))
        begin
            cnt_r <= '0;
            tick_out <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            tick_out <= 1'b0;
        end
    end
endmodule

// >>> logic/ssram_host.sv
// Host controller driving a serial SRAM over single, dual or quad lines
`timescale 1ns/1ps
module ssram_host
    import ssram_pkg::*;
#(
    parameter int unsigned HALF_DIV = ssram_pkg::SCK_HALF_DIV,
    parameter logic [5:0] QUAD_DUMMY_CLKS = 6'h02
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic busy_out,
    output logic cs_n_out,
    output logic sck_out,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe_n_out,
    input wire logic [3:0] sio_in
);
    ssram_state_type state_r;
    ssram_width_type width_r;
    ssram_width_type frame_w_r;
    ssram_cmd_type cmd_r;
    logic [23:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] rdata_r;
    logic [7:0] mode_r;
    logic err_r;
    logic recov_pend_r;
    logic [39:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [5:0] clk_cnt_r;
    logic [5:0] dummy_r;
    logic rx_on_r;
    logic [3:0] wait_r;
    logic [3:0] sio_meta_r;
    logic [3:0] sio_sync_r;
    logic sck_r;
    logic tick;
    logic run;
    logic rise;
    logic fall;
    logic last_clk;
    logic ctrl_wr;
    logic start;
    logic refuse;
    logic frame_end;
    ssram_cmd_type p_cmd;
    ssram_width_type p_w;
    logic [39:0] p_tx;
    logic [2:0] p_bytes;
    logic [5:0] p_dummy;
    logic p_rx;
    logic [5:0] p_cpb;

    function automatic logic [5:0] clks_per_byte(input ssram_width_type w);
        case (w)
            W_DUAL: clks_per_byte = 6'h04;
            W_QUAD: clks_per_byte = 6'h02;
            default: clks_per_byte = 6'h08;
        endcase
    endfunction

    function automatic logic [39:0] shift_tx(input logic [39:0] v, input ssram_width_type w);
        case (w)
            W_DUAL: shift_tx = {v[37:0], 2'h0};
            W_QUAD: shift_tx = {v[35:0], 4'h0};
            default: shift_tx = {v[38:0], 1'b0};
        endcase
    endfunction

    // Line 3 stays a driven-high pause pin outside quad width
    function automatic logic [3:0] tx_lines(input logic [39:0] v, input ssram_width_type w);
        case (w)
            W_DUAL: tx_lines = {2'h2, v[39:38]};
            W_QUAD: tx_lines = v[39:36];
            default: tx_lines = {3'h4, v[39]};
        endcase
    endfunction

    function automatic logic [3:0] tx_oe_n(input ssram_width_type w);
        case (w)
            W_DUAL: tx_oe_n = 4'h4;
            W_QUAD: tx_oe_n = 4'h0;
            default: tx_oe_n = 4'h6;
        endcase
    endfunction

    function automatic logic [3:0] rx_oe_n(input ssram_width_type w);
        case (w)
            W_DUAL: rx_oe_n = 4'h7;
            W_QUAD: rx_oe_n = 4'hF;
            default: rx_oe_n = 4'h6;
        endcase
    endfunction

    ssram_tick #(
        .DIV(HALF_DIV)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .run_in(run),
        .tick_out(tick)
    );

    assign run = (state_r == ST_TX) || (state_r == ST_DUMMY) || (state_r == ST_RX);
    assign rise = run && tick && !sck_r;
    assign fall = run && tick && sck_r;
    assign last_clk = (clk_cnt_r == 6'h01);
    assign ctrl_wr = reg_wr_in && (reg_addr_in == REG_CTRL);
    assign frame_end = (state_r == ST_HOLD) && (wait_r == 4'h1);

    // Refused: busy, or a mode write carrying the reserved addressing code
    always_comb
    begin
        refuse = 1'b0;
        if (ctrl_wr)
        begin
            if (state_r != ST_IDLE || recov_pend_r)
                refuse = 1'b1;
            else if (ssram_cmd_type'(reg_wdata_in[2:0]) == CMD_WR_MODE &&
                     wdata_r[MODE_HI:MODE_LO] == MODE_RSVD)
                refuse = 1'b1;
        end
    end

    assign start = (state_r == ST_IDLE) && (recov_pend_r || (ctrl_wr && !refuse));

    // Frame plan for the command about to start
    always_comb
    begin
        p_cmd = recov_pend_r ? CMD_RST_W : ssram_cmd_type'(reg_wdata_in[2:0]);
        p_w = width_r;
        p_tx = '0;
        p_bytes = 3'h1;
        p_dummy = 6'h00;
        p_rx = 1'b0;
        case (p_cmd)
            CMD_READ:
            begin
                p_tx = {OP_READ, addr_r, 8'h00};
                p_bytes = 3'h4;
                p_rx = 1'b1;
                if (width_r == W_DUAL)
                    p_dummy = DUAL_DUMMY_CLKS;
                else if (width_r == W_QUAD)
                    p_dummy = QUAD_DUMMY_CLKS;
            end
            CMD_WRITE:
            begin
                p_tx = {OP_WRITE, addr_r, wdata_r};
                p_bytes = 3'h5;
            end
            CMD_RD_MODE:
            begin
                p_tx = {OP_RD_MODE, 32'h0};
                p_rx = 1'b1;
            end
            CMD_WR_MODE:
            begin
                p_tx = {OP_WR_MODE, wdata_r[MODE_HI:MODE_LO], MODE_RSVD_BITS, 24'h0};
                p_bytes = 3'h2;
            end
            CMD_DUAL: p_tx = {OP_DUAL, 32'h0};
            CMD_QUAD: p_tx = {OP_QUAD, 32'h0};
            CMD_RST_W:
            begin
                p_tx = {OP_RST_W, 32'h0};
                if (recov_pend_r)
                    p_w = W_DUAL;
            end
            CMD_RECOVER:
            begin
                // Quad form first; a narrower memory sees a cut frame and drops it
                p_tx = {OP_RST_W, 32'h0};
                p_w = W_QUAD;
            end
            default: p_tx = '0;
        endcase
        p_cpb = clks_per_byte(p_w);
    end

    // Two-flop synchroniser for the data lines
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sio_meta_r <= 4'h0;
            sio_sync_r <= 4'h0;
        end
        else
        begin
            sio_meta_r <= sio_in;
            sio_sync_r <= sio_meta_r;
        end
    end

    // Frame sequencer
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r <= ST_IDLE;
            frame_w_r <= W_SINGLE;
            cmd_r <= CMD_READ;
            tx_sh_r <= '0;
            rx_sh_r <= 8'h00;
            clk_cnt_r <= 6'h00;
            dummy_r <= 6'h00;
            rx_on_r <= 1'b0;
            wait_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (start)
                    begin
                        cmd_r <= p_cmd;
                        frame_w_r <= p_w;
                        tx_sh_r <= p_tx;
                        clk_cnt_r <= 6'(p_bytes) * p_cpb;
                        dummy_r <= p_dummy;
                        rx_on_r <= p_rx;
                        wait_r <= CS_SETUP_CYC;
                        state_r <= ST_SETUP;
                    end
                ST_SETUP:
                    if (wait_r == 4'h1)
                        state_r <= ST_TX;
                    else
                        wait_r <= wait_r - 4'h1;
                ST_TX:
                    if (fall)
                    begin
                        tx_sh_r <= shift_tx(tx_sh_r, frame_w_r);
                        clk_cnt_r <= clk_cnt_r - 6'h01;
                        if (last_clk)
                        begin
                            if (dummy_r != 6'h00)
                            begin
                                clk_cnt_r <= dummy_r;
                                state_r <= ST_DUMMY;
                            end
                            else if (rx_on_r)
                            begin
                                clk_cnt_r <= clks_per_byte(frame_w_r);
                                state_r <= ST_RX;
                            end
                            else
                            begin
                                wait_r <= CS_HOLD_CYC;
                                state_r <= ST_HOLD;
                            end
                        end
                    end
                ST_DUMMY:
                    if (fall)
                    begin
                        clk_cnt_r <= clk_cnt_r - 6'h01;
                        if (last_clk)
                        begin
                            clk_cnt_r <= clks_per_byte(frame_w_r);
                            state_r <= ST_RX;
                        end
                    end
                ST_RX:
                begin
                    // Memory drives after the falling edge, so sample on the rising one
                    if (rise)
                    begin
                        case (frame_w_r)
                            W_DUAL: rx_sh_r <= {rx_sh_r[5:0], sio_sync_r[1:0]};
                            W_QUAD: rx_sh_r <= {rx_sh_r[3:0], sio_sync_r};
                            default: rx_sh_r <= {rx_sh_r[6:0], sio_sync_r[1]};
                        endcase
                    end
                    if (fall)
                    begin
                        clk_cnt_r <= clk_cnt_r - 6'h01;
                        if (last_clk)
                        begin
                            wait_r <= CS_HOLD_CYC;
                            state_r <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD:
                    if (wait_r == 4'h1)
                    begin
                        wait_r <= CS_DISABLE_CYC;
                        state_r <= ST_GAP;
                    end
                    else
                        wait_r <= wait_r - 4'h1;
                ST_GAP:
                    if (wait_r == 4'h1)
                        state_r <= ST_IDLE;
                    else
                        wait_r <= wait_r - 4'h1;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Pin drivers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cs_n_out <= 1'b1;
            sck_r <= 1'b0;
            sio_out <= 4'h8;
            sio_oe_n_out <= 4'h7;
        end
        else
        begin
            if (start)
            begin
                cs_n_out <= 1'b0;
                sio_out <= tx_lines(p_tx, p_w);
                sio_oe_n_out <= tx_oe_n(p_w);
            end
            else if (frame_end)
            begin
                cs_n_out <= 1'b1;
                sio_out <= 4'h8;
                sio_oe_n_out <= 4'h7;
            end
            else if (fall && state_r == ST_TX)
            begin
                if (last_clk && (dummy_r != 6'h00 || rx_on_r))
                begin
                    sio_out <= 4'h8;
                    sio_oe_n_out <= rx_oe_n(frame_w_r);
                end
                else
                    sio_out <= tx_lines(shift_tx(tx_sh_r, frame_w_r), frame_w_r);
            end
            if (run && tick)
                sck_r <= !sck_r;
        end
    end

    assign sck_out = sck_r;

    // Controller state kept across frames
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            width_r <= W_SINGLE;
            mode_r <= MODE_RESET;
            rdata_r <= 8'h00;
            recov_pend_r <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            busy_out <= (state_r != ST_IDLE) || start || recov_pend_r;
            if (state_r == ST_RX && fall && last_clk)
            begin
                rdata_r <= rx_sh_r;
                if (cmd_r == CMD_RD_MODE)
                    mode_r <= rx_sh_r;
            end
            if (frame_end)
            begin
                case (cmd_r)
                    CMD_DUAL: width_r <= W_DUAL;
                    CMD_QUAD: width_r <= W_QUAD;
                    CMD_RST_W:
                    begin
                        width_r <= W_SINGLE;
                        recov_pend_r <= 1'b0;
                    end
                    CMD_RECOVER: recov_pend_r <= 1'b1;
                    CMD_WR_MODE: mode_r <= {wdata_r[MODE_HI:MODE_LO], MODE_RSVD_BITS};
                    default: width_r <= width_r;
                endcase
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            addr_r <= 24'h000000;
            wdata_r <= 8'h00;
            err_r <= 1'b0;
        end
        else
        begin
            if (reg_wr_in && reg_addr_in == REG_ADDR)
                addr_r <= reg_wdata_in[23:0];
            if (reg_wr_in && reg_addr_in == REG_WDATA && state_r == ST_IDLE)
                wdata_r <= reg_wdata_in[7:0];
            // A refusal in the clearing cycle keeps the flag set
            if (refuse)
                err_r <= 1'b1;
            else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_ERR_POS])
                err_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            reg_rdata_out <= 32'h00000000;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                REG_ADDR: reg_rdata_out <= {8'h00, addr_r};
                REG_WDATA: reg_rdata_out <= {24'h000000, wdata_r};
                REG_RDATA: reg_rdata_out <= {24'h000000, rdata_r};
                REG_STATUS: reg_rdata_out <= {16'h0000, mode_r, 3'h0, err_r,
                                              1'b0, width_r, busy_out};
                default: reg_rdata_out <= 32'h00000000;
            endcase
        end
        else
            reg_rdata_out <= 32'h00000000;
    end
endmodule

// >>> test/ssram_host_properties.sv
// Port-level assertions for the serial SRAM host controller
`timescale 1ns/1ps
module ssram_host_checker
    import ssram_pkg::*;
#(
    parameter int unsigned HALF_DIV = 4
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic cs_n_out,
    input wire logic sck_out,
    input wire logic [3:0] sio_out,
    input wire logic [3:0] sio_oe_n_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    logic [7:0] hi_cnt;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= sck_out ? hi_cnt + 8'h01 : 8'h00;
    end
    sequence s_clock_quiet;
        !sck_out [*3];
    endsequence
    sequence s_deselected;
        cs_n_out [*3];
    endsequence
    property p_sck_framed;
        cs_n_out |-> !sck_out;
    endproperty
    a_sck_framed: assert property (p_sck_framed) else $error("clock outside frame");
    property p_cs_setup;
        $fell(cs_n_out) |-> s_clock_quiet;
    endproperty
    a_cs_setup: assert property (p_cs_setup) else $error("clock too soon");
    property p_cs_hold;
        $rose(cs_n_out) |-> !$past(sck_out) && !$past(sck_out, 2) && !$past(sck_out, 3);
    endproperty
    a_cs_hold: assert property (p_cs_hold) else $error("select hold short");
    property p_cs_gap;
        $rose(cs_n_out) |-> s_deselected;
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("deselect gap short");
    property p_half_high;
        $fell(sck_out) |-> hi_cnt == 8'(HALF_DIV);
    endproperty
    a_half_high: assert property (p_half_high) else $error("clock high time");
    property p_data_steady;
        sck_out && $past(sck_out) |-> $stable(sio_out) && $stable(sio_oe_n_out);
    endproperty
    a_data_steady: assert property (p_data_steady) else $error("data moved");
    property p_idle_lines;
        cs_n_out |-> sio_oe_n_out == 4'h7 && sio_out[3];
    endproperty
    a_idle_lines: assert property (p_idle_lines) else $error("idle lines");
    property p_line3_high;
        !sio_oe_n_out[3] && sio_oe_n_out[2] |-> sio_out[3];
    endproperty
    a_line3_high: assert property (p_line3_high) else $error("line3 low");
    property p_quad_lines;
        !sio_oe_n_out[2] |-> sio_oe_n_out == 4'h0;
    endproperty
    a_quad_lines: assert property (p_quad_lines) else $error("partial quad");
    property p_rdata_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_mode_low;
        $past(reg_rd_in) && $past(reg_addr_in) == REG_STATUS |->
            reg_rdata_out[ST_MODE_LO +: 6] == 6'h00;
    endproperty
    a_mode_low: assert property (p_mode_low) else $error("mode low bits");
endmodule

bind ssram_host ssram_host_checker #(.HALF_DIV(HALF_DIV)) u_ssram_host_checker (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .cs_n_out(cs_n_out),
    .sck_out(sck_out),
    .sio_out(sio_out),
    .sio_oe_n_out(sio_oe_n_out)
);

// >>> test/ssram_mem_model.sv
// Behavioural serial SRAM answering on one, two or four lines
`timescale 1ns/1ps
module ssram_mem_model
    import ssram_pkg::*;
#(
    parameter int QD = 2
) (
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic [3:0] sio_in,
    output logic [3:0] sio_out,
    output logic [1:0] width_out,
    output logic [7:0] mode_out
);
    logic [7:0] mem [0:262143];
    logic [39:0] sh;
    logic [17:0] adr;
    logic [7:0] op;
    logic [7:0] ob;
    logic [3:0] val;
    logic [3:0] en;
    int k;
    int w;
    int ost;
    initial
    begin
        width_out = W_SINGLE;
        mode_out = MODE_RESET;
        sio_out = 4'h5;
        op = 8'h00;
        k = 0;
    end
    assign w = (width_out == W_QUAD) ? 4 : (width_out == W_DUAL) ? 2 : 1;
    assign ost = (op == OP_RD_MODE) ? 8 / w : 32 / w + (w == 2 ? 4 : w == 4 ? QD : 0);
    always @(negedge cs_n_in)
    begin
        k = 0;
        op = 8'h00;
    end
    always @(posedge sck_in)
    begin
        if (!cs_n_in)
        begin
            k = k + 1;
            case (w)
                1: sh = {sh[38:0], sio_in[0]};
                2: sh = {sh[37:0], sio_in[1:0]};
                default: sh = {sh[35:0], sio_in};
            endcase
            if (k * w == 8)
                op = sh[7:0];
            if (k * w == 16 && op == OP_WR_MODE)
                mode_out = sh[7:0];
            if (k * w == 32)
                adr = sh[17:0];
            if (k * w == 40 && op == OP_WRITE)
                mem[sh[25:8]] = sh[7:0];
        end
    end
    // Released lines flip on every fall so a stale level is never read as data
    always @(negedge sck_in)
    begin
        en = 4'h0;
        if (!cs_n_in && (op == OP_READ || op == OP_RD_MODE))
        begin
            if (k == ost)
            begin
                ob = (op == OP_READ) ? mem[adr] : mode_out;
                // Pointer moves on after each byte; page mode stays inside its 32 bytes
                if (mode_out[MODE_HI:MODE_LO] == MODE_PAGE)
                    adr = {adr[17:5], adr[4:0] + 5'h01};
                else
                    adr = adr + 18'h00001;
            end
            if (k >= ost && k < ost + 8 / w)
            begin
                en = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h2;
                val = (w == 4) ? ob[7:4] : (w == 2) ? {2'b00, ob[7:6]} : {2'b00, ob[7], 1'b0};
                ob = ob << w;
            end
        end
        sio_out = (val & en) | (~sio_out & ~en);
    end
    always @(posedge cs_n_in)
    begin
        if (op == OP_DUAL)
            width_out = W_DUAL;
        if (op == OP_QUAD)
            width_out = W_QUAD;
        if (op == OP_RST_W)
            width_out = W_SINGLE;
        op = 8'h00;
        sio_out = ~sio_out;
    end
endmodule

// >>> test/ssram_host_test.sv
// Self-checking bench for the serial SRAM host controller
`timescale 1ns/1ps
module ssram_host_test;
    import ssram_pkg::*;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic [31:0] rd_val;
    logic busy_out;
    logic cs_n_out;
    logic sck_out;
    logic [3:0] sio_out;
    logic [3:0] sio_oe_n_out;
    logic [3:0] sio_in;
    logic [3:0] mem_sio;
    logic [1:0] mem_width;
    logic [7:0] mem_mode;
    logic [7:0] dat;
    logic [23:0] adr;
    logic [1:0] codes [3] = '{MODE_BYTE, MODE_PAGE, MODE_SEQ};
    int err_total = 0;
    int cmp_count = 0;
    int seed = 26;
    always #10 clk_sys_in = ~clk_sys_in;
    assign sio_in = (sio_out & ~sio_oe_n_out) | (mem_sio & sio_oe_n_out);
    ssram_host #(.HALF_DIV(4), .QUAD_DUMMY_CLKS(6'h02)) u_ssram_host (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .cs_n_out(cs_n_out),
        .sck_out(sck_out), .sio_out(sio_out), .sio_oe_n_out(sio_oe_n_out), .sio_in(sio_in));
    ssram_mem_model #(.QD(2)) u_ssram_mem_model (.cs_n_in(cs_n_out), .sck_in(sck_out),
        .sio_in(sio_in), .sio_out(mem_sio), .width_out(mem_width), .mode_out(mem_mode));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 rd_val = reg_rdata_out;
    endtask
    // Busy stays high through the deselect gap; four more cycles follow after it drops
    task automatic idle;
        repeat (2) @(posedge clk_sys_in);
        while (busy_out !== 1'b0)
            @(posedge clk_sys_in);
        repeat (4) @(posedge clk_sys_in);
    endtask
    task automatic cmd(input logic [2:0] c);
        wr(REG_CTRL, {29'h0, c});
        idle();
    endtask
    task automatic stop_test;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd(REG_STATUS);
        check(rd_val, {16'h0, MODE_RESET, 8'h00});
        cmd(3'h2);
        rd(REG_RDATA);
        check(rd_val, {24'h0, MODE_RESET});
        for (int k = 0; k < 3; k++)
        begin
            if (k > 0)
                cmd(k == 1 ? 3'h4 : 3'h5);
            rd(REG_STATUS);
            check(32'(mem_width), 32'(k));
            check(32'(rd_val[2:1]), 32'(k));
            for (int j = 0; j < 2; j++)
            begin
                adr = (j == 0) ? 24'hFFFFFF : 24'($random(seed));
                dat = 8'($random(seed));
                wr(REG_ADDR, {8'h0, adr});
                wr(REG_WDATA, {24'h0, dat});
                cmd(3'h1);
                check(32'(u_ssram_mem_model.mem[adr[17:0]]), 32'(dat));
                cmd(3'h0);
                rd(REG_RDATA);
                check(rd_val, {24'h0, dat});
            end
            for (int m = 0; m < 3; m++)
            begin
                wr(REG_WDATA, {24'h0, codes[m], 6'h3F});
                cmd(3'h3);
                check(32'(mem_mode), {24'h0, codes[m], 6'h00});
                cmd(3'h2);
                rd(REG_RDATA);
                check(rd_val, {24'h0, codes[m], 6'h00});
            end
            if (k > 0)
                cmd(3'h6);
            check(32'(mem_width), 32'h0);
        end
        wr(REG_WDATA, 32'hC0);
        cmd(3'h3);
        rd(REG_STATUS);
        check(32'(rd_val[4]), 32'h1);
        check(32'(mem_mode), 32'(MODE_RESET));
        wr(REG_STATUS, 32'h10);
        rd(REG_STATUS);
        check(32'(rd_val[4]), 32'h0);
        wr(REG_CTRL, 32'h2);
        wr(REG_CTRL, 32'h2);
        rd(REG_STATUS);
        check(32'(rd_val[0]), 32'h1);
        idle();
        rd(REG_STATUS);
        check(32'(rd_val[4]), 32'h1);
        cmd(3'h5);
        @(posedge clk_sys_in);
        nrst_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        cmd(3'h7);
        check(32'(mem_width), 32'h0);
        check(32'(mem_mode), 32'(MODE_RESET));
        cmd(3'h2);
        rd(REG_RDATA);
        check(rd_val, {24'h0, MODE_RESET});
        rd(8'h14);
        check(rd_val, 32'h0);
        rd(REG_CTRL);
        check(rd_val, 32'h0);
        stop_test();
    end
endmodule
